/* File: verilog/asr_regmap.sv */
// Serial register map, LIN pin logic and diagnostic mux select.
// Assumes the master runs a 16-clock frame under an active-low select.
//
// What this block does
// - Reply byte one always carries the system status register.
// - Reply byte two carries the addressed register, before any write.
// - LIN transmitter is enabled only while power_stage_on is set.
// - Status shows lin_current_limit_flag while the transmitter limits current.
// - Transmit input low drives LIN dominant; high turns the driver off.
// - An undriven transmit input counts as high, keeping LIN recessive.
// - Receive output is high for recessive bus, low for dominant bus.
// - In stop mode the transmitter is off and the receiver stays active.
// - With lin_irq_enable set, each LIN falling edge raises an interrupt.
// - A LIN edge interrupt turns the main regulator on and requests wake-up.
// - Four-bit channel select in the mux register low nibble, reset zero.
// - Select 0-3 half-bridge sense, 4 supply, 5 temperature, others none.
// - Power output register holds only bit 1; others read zero.
// - aux_supply_on switches the auxiliary supply output; reset clears it.
// - Only frames with exactly sixteen sample edges are accepted.
// - Write data is taken on the select rising edge ending the frame.
`include "asr_defines.svh"
`default_nettype none

module asr_regmap (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           spi_sclk,
  input  wire logic           spi_ss_n,
  input  wire logic           spi_mosi,
  output var  logic           spi_miso,
  output var  logic           spi_miso_oe_n,
  input  wire logic           lin_in,
  output var  logic           lin_out,
  output var  logic           lin_oe_n,
  input  wire logic           txd,
  input  wire logic           txd_driven,
  output var  logic           rxd,
  input  wire logic           lin_cur_limit,
  input  wire logic           stop_mode,
  output var  logic           lin_irq,
  output var  logic           wake_req,
  output var  logic           main_reg_on,
  output var  asr_pkg::asr_byte_t hb_out,
  output var  asr_pkg::asr_byte_t hb_ctrl,
  output var  asr_pkg::asr_byte_t reset_mask,
  output var  asr_pkg::asr_chan_t mux_chan,
  output var  logic           aux_supply_out
);
  import asr_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Bit order: 0 sclk, 1 ss_n, 2 mosi, 3 lin, 4 txd, 5 txd_driven,
  // 6 current limit, 7 stop mode.
  asr_byte_t s1, s2, s3, filt, filt_d;
  asr_byte_t next_filt;

  always_comb begin
    next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1     <= `ASR_SYNC_RST;
      s2     <= `ASR_SYNC_RST;
      s3     <= `ASR_SYNC_RST;
      filt   <= `ASR_SYNC_RST;
      filt_d <= `ASR_SYNC_RST;
    end else begin
      s1     <= {stop_mode, lin_cur_limit, txd_driven, txd,
                 lin_in, spi_mosi, spi_ss_n, spi_sclk};
      s2     <= s1;
      s3     <= s2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  logic sclk_rise, sclk_fall, ss_fall, ss_rise, lin_fall, stop_rise;
  assign sclk_rise = filt[0] & ~filt_d[0];
  assign sclk_fall = ~filt[0] & filt_d[0];
  assign ss_fall   = ~filt[1] & filt_d[1];
  assign ss_rise   = filt[1] & ~filt_d[1];
  assign lin_fall  = ~filt[3] & filt_d[3];
  assign stop_rise = filt[7] & ~filt_d[7];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  asr_state_e state, next_state;
  logic [4:0] cnt, next_cnt, rcnt, next_rcnt;
  logic [15:0] rx, next_rx, tx, next_tx;
  asr_byte_t sys_ctl, next_sys_ctl, irq_msk, next_irq_msk;
  asr_byte_t next_hb_out, next_hb_ctrl, next_reset_mask;
  logic [3:0] mux_sel, next_mux_sel;
  logic lin_flag, next_lin_flag, next_aux, next_miso, next_miso_oe_n;
  logic next_lin_oe_n, next_rxd, next_lin_irq, next_wake, next_main;
  asr_chan_t next_mux_chan;
  asr_byte_t status;
  logic tx_en, txd_eff, wr_ok;

  assign status = {1'b0, filt[`ASR_B_CUR_LIM], 6'h00};
  assign lin_out = 1'b0;

  function automatic asr_chan_t chan_dec(input logic [3:0] sel);
    chan_dec = '0;
    if (sel < 4'h6) begin
      chan_dec[sel[2:0]] = 1'b1;
    end
  endfunction

  function automatic asr_byte_t rd_reg(input asr_addr_t a);
    case (a)
      `ASR_A_HB_OUT:   rd_reg = hb_out;
      `ASR_A_HB_CTL:   rd_reg = hb_ctrl;
      `ASR_A_SYS_CTL:  rd_reg = sys_ctl;
      `ASR_A_IRQ_MSK:  rd_reg = irq_msk;
      `ASR_A_IRQ_FLG:  rd_reg = {2'b00, lin_flag, 5'h00};
      `ASR_A_RST_MSK:  rd_reg = reset_mask;
      `ASR_A_MUX_SEL:  rd_reg = {4'h0, mux_sel};
      `ASR_A_PWR_OUT:  rd_reg = {6'h00, aux_supply_out, 1'b0};
      `ASR_A_SYS_STAT: rd_reg = status;
      default:         rd_reg = 8'h00;
    endcase
  endfunction

  // Frame word once sixteen bits are in, first bit on top:
  // [15:11] address, [10] read flag, [9] parity, [8] unused,
  // [7:0] write data. Parity is the XOR of address and read flag,
  // and is checked on writes only.
  // Valid write: exact length, write type, good even parity
  assign wr_ok = (cnt == `ASR_FRAME_LEN) && !rx[10]
                 && ((^rx[15:10]) == rx[9]);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_rcnt       = rcnt;
    next_rx         = rx;
    next_tx         = tx;
    next_miso       = spi_miso;
    next_miso_oe_n  = spi_miso_oe_n;
    next_hb_out     = hb_out;
    next_hb_ctrl    = hb_ctrl;
    next_sys_ctl    = sys_ctl;
    next_irq_msk    = irq_msk;
    next_reset_mask = reset_mask;
    next_mux_sel    = mux_sel;
    next_aux        = aux_supply_out;
    next_lin_flag   = lin_flag;
    case (state)
      ASR_IDLE: begin
        if (ss_fall) begin
          next_state     = ASR_FRAME;
          next_cnt       = 5'd0;
          next_rcnt      = 5'd0;
          next_rx        = 16'h0000;
          next_tx        = {status, 8'h00};
          next_miso_oe_n = 1'b0;
        end
      end
      ASR_FRAME: begin
        if (ss_rise) begin
          next_state     = ASR_IDLE;
          next_miso_oe_n = 1'b1;
          if (wr_ok) begin
            case (rx[15:11])
              `ASR_A_HB_OUT:  next_hb_out = rx[7:0] & `ASR_M_HB_OUT;
              `ASR_A_HB_CTL:  next_hb_ctrl = rx[7:0] & `ASR_M_HB_CTL;
              `ASR_A_SYS_CTL: next_sys_ctl = rx[7:0] & `ASR_M_SYS_CTL;
              `ASR_A_IRQ_MSK: next_irq_msk = rx[7:0] & `ASR_M_IRQ_MSK;
              `ASR_A_RST_MSK: next_reset_mask = rx[7:0] & `ASR_M_RST_MSK;
              `ASR_A_MUX_SEL: next_mux_sel = rx[3:0];
              `ASR_A_PWR_OUT: next_aux = rx[`ASR_B_AUX];
              `ASR_A_IRQ_FLG: begin
                if (rx[`ASR_B_LIN_EDGE]) begin
                  next_lin_flag = 1'b0;
                end
              end
              default: ;
            endcase
          end
        end else begin
          if (sclk_fall) begin
            next_rx = {rx[14:0], filt[2]};
            if (cnt != `ASR_CNT_OVER) begin
              next_cnt = cnt + 5'd1;
            end
            if (cnt == `ASR_PAR_CNT - 5'd1) begin
              next_tx[7:0] = rd_reg(next_rx[6:2]);
            end
          end
          if (sclk_rise && rcnt < `ASR_FRAME_LEN) begin
            next_miso = tx[4'hF - rcnt[3:0]];
            next_rcnt = rcnt + 5'd1;
          end
        end
      end
      default: next_state = ASR_IDLE;
    endcase
    // Edge sets the flag even in the cycle it is cleared
    if (lin_fall) begin
      next_lin_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // LIN pin, wake-up and mux outputs
  // ----------------------------------------------------------------
  always_comb begin
    tx_en   = sys_ctl[`ASR_B_PWR_STAGE] & ~filt[7];
    txd_eff = filt[5] ? filt[4] : 1'b1;
    next_lin_oe_n = ~(tx_en & ~txd_eff);
    next_rxd      = filt[3];
    next_lin_irq  = lin_flag & irq_msk[`ASR_B_LIN_IRQ_EN];
    next_wake     = lin_fall & irq_msk[`ASR_B_LIN_IRQ_EN];
    next_main     = main_reg_on;
    if (stop_rise) begin
      next_main = 1'b0;
    end
    if (next_wake) begin
      next_main = 1'b1;
    end
    next_mux_chan = chan_dec(mux_sel);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state          <= ASR_IDLE;
      cnt            <= 5'd0;
      rcnt           <= 5'd0;
      rx             <= 16'h0000;
      tx             <= 16'h0000;
      spi_miso       <= 1'b0;
      spi_miso_oe_n  <= 1'b1;
      hb_out         <= `ASR_RST_BYTE;
      hb_ctrl        <= `ASR_RST_BYTE;
      sys_ctl        <= `ASR_RST_BYTE;
      irq_msk        <= `ASR_RST_BYTE;
      reset_mask     <= `ASR_RST_BYTE;
      mux_sel        <= 4'h0;
      aux_supply_out <= 1'b0;
      lin_flag       <= 1'b0;
      lin_oe_n       <= 1'b1;
      rxd            <= 1'b1;
      lin_irq        <= 1'b0;
      wake_req       <= 1'b0;
      main_reg_on    <= 1'b0;
      mux_chan       <= 6'h01;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      rcnt           <= next_rcnt;
      rx             <= next_rx;
      tx             <= next_tx;
      spi_miso       <= next_miso;
      spi_miso_oe_n  <= next_miso_oe_n;
      hb_out         <= next_hb_out;
      hb_ctrl        <= next_hb_ctrl;
      sys_ctl        <= next_sys_ctl;
      irq_msk        <= next_irq_msk;
      reset_mask     <= next_reset_mask;
      mux_sel        <= next_mux_sel;
      aux_supply_out <= next_aux;
      lin_flag       <= next_lin_flag;
      lin_oe_n       <= next_lin_oe_n;
      rxd            <= next_rxd;
      lin_irq        <= next_lin_irq;
      wake_req       <= next_wake;
      main_reg_on    <= next_main;
      mux_chan       <= next_mux_chan;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  status_first_a: assert property (
    ss_fall && state == ASR_IDLE |=> tx[15:8] == {1'b0, $past(filt[6]), 6'h00})
    else $error("status byte not loaded at frame start");
  limit_flag_a: assert property (
    ss_fall && state == ASR_IDLE && filt[6] |=> tx[14])
    else $error("current limit flag missing from status");
  old_data_a: assert property (
    ss_rise && state == ASR_FRAME && wr_ok && rx[15:11] == `ASR_A_MUX_SEL
    |-> tx[3:0] == mux_sel ##1 mux_sel == $past(rx[3:0]))
    else $error("reply byte not the value before the write");
  pwr_stage_off_a: assert property (
    !sys_ctl[`ASR_B_PWR_STAGE] |=> lin_oe_n)
    else $error("LIN driven without power stage on");
  txd_low_a: assert property (
    tx_en && filt[5] && !filt[4] |=> !lin_oe_n)
    else $error("LIN not dominant for low transmit input");
  undriven_a: assert property (
    !filt[5] |=> lin_oe_n)
    else $error("undriven transmit input drove LIN");
  rxd_follow_a: assert property (
    $fell(filt[3]) |=> !rxd)
    else $error("receive output missed dominant bus");
  stop_tx_a: assert property (
    filt[7] |=> lin_oe_n ##0 rxd == $past(filt[3]))
    else $error("stop mode left transmitter on");
  edge_irq_a: assert property (
    lin_fall && irq_msk[`ASR_B_LIN_IRQ_EN] |=> ##1 lin_irq)
    else $error("LIN edge gave no interrupt");
  wake_up_a: assert property (
    lin_fall && irq_msk[`ASR_B_LIN_IRQ_EN] |=> wake_req && main_reg_on)
    else $error("LIN edge gave no wake-up");
  mux_none_a: assert property (
    mux_sel > 4'h5 |=> mux_chan == 6'h00)
    else $error("unused select routed a channel");
  bad_len_a: assert property (
    ss_rise && state == ASR_FRAME && cnt != `ASR_FRAME_LEN
    |=> $stable(mux_sel) && $stable(aux_supply_out) && $stable(sys_ctl))
    else $error("frame of wrong length was taken");
  aux_write_a: assert property (
    ss_rise && state == ASR_FRAME && wr_ok && rx[15:11] == `ASR_A_PWR_OUT
    |=> aux_supply_out == $past(rx[`ASR_B_AUX]))
    else $error("aux supply bit not written");

  write_frame_c: cover property (ss_rise && state == ASR_FRAME && wr_ok);
  read_frame_c: cover property (
    ss_rise && state == ASR_FRAME && cnt == `ASR_FRAME_LEN && rx[10]);
  lin_wake_c: cover property (wake_req);
  flag_clear_c: cover property (lin_flag ##1 !lin_flag);
  short_frame_c: cover property (
    ss_rise && state == ASR_FRAME && cnt < `ASR_FRAME_LEN);

endmodule // asr_regmap

`default_nettype wire

/* File: verilog/asr_defines.svh */
// Constants of the analog die serial register map.
// Assumes inclusion by bare name from design and bench files.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ASR_A_HB_OUT   5'h01
`define ASR_A_HB_CTL   5'h02
`define ASR_A_SYS_CTL  5'h03
`define ASR_A_IRQ_MSK  5'h04
`define ASR_A_IRQ_FLG  5'h05
`define ASR_A_RST_MSK  5'h06
`define ASR_A_MUX_SEL  5'h07
`define ASR_A_RSVD_A   5'h08
`define ASR_A_RSVD_B   5'h09
`define ASR_A_WDG_CTL  5'h0A
`define ASR_A_PWR_OUT  5'h0B
`define ASR_A_SYS_STAT 5'h0C

// ----------------------------------------------------------------
// Writable bits per register
// ----------------------------------------------------------------
`define ASR_M_HB_OUT   8'hFF
`define ASR_M_HB_CTL   8'hC7
`define ASR_M_SYS_CTL  8'hE0
`define ASR_M_IRQ_MSK  8'h3E
`define ASR_M_RST_MSK  8'h83
`define ASR_M_MUX_SEL  8'h0F
`define ASR_M_PWR_OUT  8'h02

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASR_B_PWR_STAGE  7
`define ASR_B_CUR_LIM    6
`define ASR_B_LIN_IRQ_EN 5
`define ASR_B_LIN_EDGE   5
`define ASR_B_AUX        1

// ----------------------------------------------------------------
// Reset values and frame counts
// ----------------------------------------------------------------
`define ASR_RST_BYTE   8'h00
`define ASR_SYNC_RST   8'h1A
`define ASR_FRAME_LEN  5'd16
`define ASR_CNT_OVER   5'd17
`define ASR_PAR_CNT    5'd7
`define ASR_MUX_CHANS  6

`endif

/* File: verilog/asr_pkg.sv */
// Types shared by the analog die serial register map.
// Assumes nothing of its surroundings.
`default_nettype none

package asr_pkg;
  typedef logic [7:0] asr_byte_t;
  typedef logic [4:0] asr_addr_t;
  typedef logic [5:0] asr_chan_t;
  typedef enum {ASR_IDLE, ASR_FRAME} asr_state_e;
endpackage : asr_pkg

`default_nettype wire

/* File: bench/asr_mcu_model.sv */
// Model of the on-package microcontroller: serial master and LIN transmit pin.
// Assumes the device answers each pin edge within five system clocks.
`default_nettype none

module asr_mcu_model (
  output var  logic spi_sclk,
  output var  logic spi_ss_n,
  output var  logic spi_mosi,
  output var  logic txd,
  output var  logic txd_driven,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    spi_sclk   = 1'b0;
    spi_ss_n   = 1'b1;
    spi_mosi   = 1'b0;
    txd        = 1'b1;
    txd_driven = 1'b0;
  end

  // ------------------------------------------------------------
  // One frame of n clocks; reply bit taken just before next rise
  // ------------------------------------------------------------
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx       = 16'h0000;
    spi_ss_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      if (i > 0 && i < 17) rx[16 - i] = spi_miso;
      spi_mosi = (i < 16) ? tx[15 - i] : 1'b0;
      spi_sclk = 1'b1;
      #40;
      spi_sclk = 1'b0;
      #40;
    end
    if (n == 16) rx[0] = spi_miso;
    spi_ss_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #120;
  endtask

  // Released pin shows the inverse of its last value
  task automatic set_txd(input logic drv, input logic v);
    txd_driven = drv;
    txd        = drv ? v : ~txd;
  endtask
endmodule // asr_mcu_model

`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the serial register map and LIN pin logic.
// Assumes asr_defines.svh and asr_pkg are compiled first.
`include "asr_defines.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;

  logic      clk = 1'b0;
  logic      nrst, sclk, ss_n, mosi, miso, miso_oe_n, miso_w;
  logic      lin_w, lin_out, lin_oe_n, txd, txd_drv, rxd, ext_dom;
  logic      cur_lim, stop, irq, wake, mreg, aux;
  asr_chan_t mux_chan;
  asr_byte_t hbo, hbc, rmask;
  logic [15:0] rx;
  int        mismatches = 0;
  int        tests_run  = 0;

  always #5 clk = ~clk;

  // Open-drain LIN wire with pull-up; released miso shows the inverse
  assign lin_w  = ((lin_oe_n === 1'b0) ? lin_out : 1'b1) & ~ext_dom;
  assign miso_w = (miso_oe_n === 1'b0) ? miso : ~miso;

  asr_regmap u_asr_regmap (
    .clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_ss_n(ss_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(miso_oe_n),
    .lin_in(lin_w), .lin_out(lin_out), .lin_oe_n(lin_oe_n), .txd(txd),
    .txd_driven(txd_drv), .rxd(rxd), .lin_cur_limit(cur_lim),
    .stop_mode(stop), .lin_irq(irq), .wake_req(wake), .main_reg_on(mreg),
    .hb_out(hbo), .hb_ctrl(hbc), .reset_mask(rmask), .mux_chan(mux_chan),
    .aux_supply_out(aux)
  );

  asr_mcu_model u_asr_mcu_model (
    .spi_sclk(sclk), .spi_ss_n(ss_n), .spi_mosi(mosi), .txd(txd),
    .txd_driven(txd_drv), .spi_miso(miso_w)
  );

  // ------------------------------------------------------------
  // Checking and access tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0:       pick = lin_oe_n;
      1:       pick = rxd;
      2:       pick = wake;
      default: pick = irq;
    endcase
  endfunction

  task automatic wait_sig(input string nm, input int s, input logic v);
    int k;
    k = 0;
    while (pick(s) !== v && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk(nm, {7'h00, v}, {7'h00, pick(s)});
    if (k == 50) tally_and_finish();
  endtask

  task automatic acc(input asr_addr_t a, input logic rw, input asr_byte_t d,
                     input asr_byte_t es, input asr_byte_t ed);
    logic [15:0] r;
    u_asr_mcu_model.xfer({a, rw, ^{rw, a}, 1'b0, d}, 16, r);
    chk("status byte", es, r[15:8]);
    chk("data byte", ed, r[7:0]);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] prev;
    nrst = 1'b0;
    ext_dom = 1'b0;
    cur_lim = 1'b0;
    stop = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("mux_chan", 8'h01, {2'b00, mux_chan});
    for (int a = 1; a < 14; a++)
      acc(5'((a == 13) ? 31 : a), 1'b1, 8'hFF, 8'h00, 8'h00);
    prev = 8'h00;
    for (int v = 0; v < 16; v++) begin
      acc(`ASR_A_MUX_SEL, 1'b0, {4'hA, 4'(v)}, 8'h00, prev);
      prev = {4'h0, 4'(v)};
      chk("mux_chan", (v < 6) ? 8'(1 << v) : 8'h00, {2'b00, mux_chan});
    end
    u_asr_mcu_model.xfer(16'h3A03, 15, rx);
    chk("status byte", 8'h00, rx[15:8]);
    u_asr_mcu_model.xfer(16'h3A03, 17, rx);
    acc(`ASR_A_MUX_SEL, 1'b1, 8'h03, 8'h00, 8'h0F);
    acc(`ASR_A_MUX_SEL, 1'b1, 8'h00, 8'h00, 8'h0F);
    acc(`ASR_A_PWR_OUT, 1'b0, 8'h02, 8'h00, 8'h00);
    chk("aux_supply_out", 8'h01, {7'h00, aux});
    acc(`ASR_A_PWR_OUT, 1'b1, 8'h00, 8'h00, 8'h02);
    acc(`ASR_A_PWR_OUT, 1'b0, 8'h00, 8'h00, 8'h02);
    chk("aux_supply_out", 8'h00, {7'h00, aux});
    acc(`ASR_A_RSVD_A, 1'b0, 8'hFF, 8'h00, 8'h00);
    acc(`ASR_A_RSVD_A, 1'b1, 8'h00, 8'h00, 8'h00);
    acc(`ASR_A_HB_OUT, 1'b0, 8'hA5, 8'h00, 8'h00);
    acc(`ASR_A_HB_CTL, 1'b0, 8'hFF, 8'h00, 8'h00);
    acc(`ASR_A_RST_MSK, 1'b0, 8'hFF, 8'h00, 8'h00);
    acc(`ASR_A_HB_CTL, 1'b1, 8'h00, 8'h00, 8'hC7);
    chk("hb_out", 8'hA5, hbo);
    chk("hb_ctrl", 8'hC7, hbc);
    chk("reset_mask", 8'h83, rmask);
    // Stop mode: transmitter held off, wake-up edge still seen
    acc(`ASR_A_SYS_CTL, 1'b0, 8'h80, 8'h00, 8'h00);
    acc(`ASR_A_IRQ_MSK, 1'b0, 8'h20, 8'h00, 8'h00);
    stop = 1'b1;
    u_asr_mcu_model.set_txd(1'b1, 1'b0);
    repeat (20) @(negedge clk);
    chk("lin_oe_n", 8'h01, {7'h00, lin_oe_n});
    ext_dom = 1'b1;
    wait_sig("wake_req", 2, 1'b1);
    chk("main_reg_on", 8'h01, {7'h00, mreg});
    wait_sig("lin_irq", 3, 1'b1);
    wait_sig("rxd", 1, 1'b0);
    ext_dom = 1'b0;
    wait_sig("rxd", 1, 1'b1);
    stop = 1'b0;
    wait_sig("lin_oe_n", 0, 1'b0);
    u_asr_mcu_model.set_txd(1'b1, 1'b1);
    wait_sig("lin_oe_n", 0, 1'b1);
    acc(`ASR_A_IRQ_FLG, 1'b0, 8'h20, 8'h00, 8'h20);
    wait_sig("lin_irq", 3, 1'b0);
    acc(`ASR_A_IRQ_FLG, 1'b1, 8'h00, 8'h00, 8'h00);
    u_asr_mcu_model.set_txd(1'b0, 1'b0);
    repeat (20) @(negedge clk);
    chk("lin_oe_n", 8'h01, {7'h00, lin_oe_n});
    u_asr_mcu_model.set_txd(1'b1, 1'b0);
    wait_sig("lin_oe_n", 0, 1'b0);
    cur_lim = 1'b1;
    repeat (10) @(negedge clk);
    acc(`ASR_A_SYS_CTL, 1'b1, 8'h00, 8'h40, 8'h80);
    acc(`ASR_A_SYS_CTL, 1'b0, 8'h00, 8'h40, 8'h80);
    wait_sig("lin_oe_n", 0, 1'b1);
    cur_lim = 1'b0;
    // Second reset in mid-run clears the registers again
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("mux_chan", 8'h01, {2'b00, mux_chan});
    acc(`ASR_A_MUX_SEL, 1'b1, 8'h00, 8'h00, 8'h00);
    acc(`ASR_A_PWR_OUT, 1'b1, 8'h00, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
